// ==== hdl/sac_pkg.sv ====
// package: register map, field layout and types of the converter control block
package sac_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_REF_CTRL = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH = 8'h0C;
  localparam logic [7:0] OFF_RES_LOW = 8'h10;
  localparam logic [7:0] OFF_WIN_UPPER = 8'h14;
  localparam logic [7:0] OFF_WIN_LOWER = 8'h18;
  localparam logic [7:0] OFF_WIN_CTRL = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // converter_control_one fields
  localparam int BIT_START = 7;
  localparam int BIT_CONT = 5;
  localparam int BIT_EXT = 4;
  localparam int BIT_WCM = 2;
  localparam int BIT_POWER = 1;
  // converter_control_two fields
  localparam int BIT_ALIGN = 7;
  localparam int POS_CHANNEL = 4;
  localparam int POS_PRESCALE = 0;
  // reference_control_register field
  localparam int BIT_REF_EN = 7;
  // window control fields
  localparam int BIT_SENSE = 0;
  localparam int BIT_QUALIFY = 1;
  // irq status and mask field
  localparam int BIT_DONE = 0;
  // reset values
  localparam logic [3:0] RST_PRESCALE = 4'h0;
  localparam logic [2:0] RST_CHANNEL = 3'h0;
  localparam logic [7:0] RST_WINDOW = 8'h00;
  // conversion timing in converter clock periods
  localparam logic [3:0] SAMPLE_PERIODS = 4'h2;
  localparam logic [3:0] LAST_BIT_PERIOD = 4'hB;
  localparam logic [3:0] LAST_PERIOD = 4'hF;
  // converter clock limits software must meet, and their cycle counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int TACLK_MIN_NS = 1000;
  localparam int TACLK_MAX_NS = 6250;
  localparam int TACLK_MIN_CYC = (TACLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TACLK_MAX_CYC = TACLK_MAX_NS / CLK_PERIOD_NS;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_CONVERT = 2'h1
  } sac_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } sac_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sac_axi_rsp_t;

  typedef struct packed {
    logic converter_enable;
    logic reference_enable;
    logic [2:0] channel_select;
    logic sample_hold;
    logic [9:0] dac_code;
  } sac_analog_t;
endpackage

// ==== hdl/sac_conv_ctrl.sv ====
// successive-approximation converter control with an AXI4-Lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sac_conv_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sac_pkg::sac_axi_req_t axi_req,
  output sac_pkg::sac_axi_rsp_t axi_rsp,
  input wire logic comparator_high,
  input wire logic external_start_pin_n,
  output sac_pkg::sac_analog_t analog,
  output logic irq
);

  typedef struct packed {
    sac_pkg::sac_fsm_t fsm;
    logic [3:0] pre_cnt;
    logic [3:0] period;
    logic [9:0] sar;
    logic [9:0] result;
    logic start_flag;
    logic cont;
    logic ext_sel;
    logic power_on;
    logic window_match_flag;
    logic ref_en;
    logic align;
    logic [2:0] channel;
    logic [3:0] prescale;
    logic [7:0] win_hi;
    logic [7:0] win_lo;
    logic sense;
    logic qualify;
    logic irq_status;
    logic irq_mask;
    logic [2:0] pin_sync;
    logic pin_level;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sac_state_t;

  sac_state_t s_reg;
  sac_state_t s_next;

  // register read mux, bit 32 flags a mapped address
  function automatic logic [32:0] read_word(input sac_state_t st, input logic [7:0] addr);
    logic [7:0] v;
    logic hit;
    v = 8'h00;
    hit = 1'b1;
    case ({addr[7:2], 2'b00})
      sac_pkg::OFF_CTRL_ONE: begin
        v[sac_pkg::BIT_START] = st.start_flag;
        v[sac_pkg::BIT_CONT] = st.cont;
        v[sac_pkg::BIT_EXT] = st.ext_sel;
        v[sac_pkg::BIT_WCM] = st.window_match_flag;
        v[sac_pkg::BIT_POWER] = st.power_on;
      end
      sac_pkg::OFF_CTRL_TWO: begin
        v = {st.align, st.channel, st.prescale};
      end
      sac_pkg::OFF_REF_CTRL: begin
        v[sac_pkg::BIT_REF_EN] = st.ref_en;
      end
      sac_pkg::OFF_RES_HIGH: begin
        v = st.align ? {6'h00, st.result[9:8]} : st.result[9:2];
      end
      sac_pkg::OFF_RES_LOW: begin
        v = st.result[7:0];
      end
      sac_pkg::OFF_WIN_UPPER: begin
        v = st.win_hi;
      end
      sac_pkg::OFF_WIN_LOWER: begin
        v = st.win_lo;
      end
      sac_pkg::OFF_WIN_CTRL: begin
        v[sac_pkg::BIT_SENSE] = st.sense;
        v[sac_pkg::BIT_QUALIFY] = st.qualify;
      end
      sac_pkg::OFF_IRQ_STATUS: begin
        v[sac_pkg::BIT_DONE] = st.irq_status;
      end
      sac_pkg::OFF_IRQ_MASK: begin
        v[sac_pkg::BIT_DONE] = st.irq_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return {hit, 24'h000000, v};
  endfunction

  // address decode for writes
  function automatic logic is_mapped(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    return (a <= sac_pkg::OFF_IRQ_MASK);
  endfunction

  logic [7:0] msb8;
  logic wcm_new;
  logic [3:0] bit_idx;

  // window compare against the upper eight bits of the finished result
  assign msb8 = s_reg.sar[9:2];
  assign wcm_new = s_reg.sense ^ (s_reg.win_hi <= msb8) ^ (s_reg.win_lo <= msb8);
  assign bit_idx = sac_pkg::LAST_BIT_PERIOD - s_reg.period;

  // next-state logic of the whole block
  always_comb begin
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] waddr;
    logic sw_start;
    logic ext_start;
    logic tick;
    logic done;
    logic done_irq;
    logic status_clear;
    logic [32:0] rd;
    s_next = s_reg;
    do_write = 1'b0;
    wbyte = s_reg.w_data[7:0];
    waddr = {s_reg.aw_addr[7:2], 2'b00};
    sw_start = 1'b0;
    ext_start = 1'b0;
    tick = 1'b0;
    done = 1'b0;
    done_irq = 1'b0;
    status_clear = 1'b0;
    rd = 33'h000000000;

    // start pin: three flops, level changes once the last two agree
    s_next.pin_sync = {s_reg.pin_sync[1:0], external_start_pin_n};
    if (s_reg.pin_sync[1] == s_reg.pin_sync[2]) begin
      s_next.pin_level = s_reg.pin_sync[2];
    end
    ext_start = s_reg.ext_sel && s_reg.pin_level && !s_next.pin_level;

    // write address and data channels, taken in either order
    if (axi_req.awvalid && !s_reg.aw_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_reg.w_full && !s_reg.bvalid) begin
      s_next.w_full = 1'b1;
      s_next.w_data = axi_req.wdata;
      s_next.w_strb = axi_req.wstrb;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(s_reg.aw_addr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      do_write = s_reg.w_strb[0];
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end

    // register writes, only the low byte lane carries data
    if (do_write) begin
      case (waddr)
        sac_pkg::OFF_CTRL_ONE: begin
          s_next.cont = wbyte[sac_pkg::BIT_CONT];
          s_next.ext_sel = wbyte[sac_pkg::BIT_EXT];
          s_next.power_on = wbyte[sac_pkg::BIT_POWER];
          // trigger select as written decides whether this write starts
          sw_start = wbyte[sac_pkg::BIT_START] && !wbyte[sac_pkg::BIT_EXT];
        end
        sac_pkg::OFF_CTRL_TWO: begin
          s_next.align = wbyte[sac_pkg::BIT_ALIGN];
          s_next.channel = wbyte[sac_pkg::POS_CHANNEL +: 3];
          s_next.prescale = wbyte[sac_pkg::POS_PRESCALE +: 4];
        end
        sac_pkg::OFF_REF_CTRL: begin
          s_next.ref_en = wbyte[sac_pkg::BIT_REF_EN];
        end
        sac_pkg::OFF_WIN_UPPER: begin
          s_next.win_hi = wbyte;
        end
        sac_pkg::OFF_WIN_LOWER: begin
          s_next.win_lo = wbyte;
        end
        sac_pkg::OFF_WIN_CTRL: begin
          s_next.sense = wbyte[sac_pkg::BIT_SENSE];
          s_next.qualify = wbyte[sac_pkg::BIT_QUALIFY];
        end
        sac_pkg::OFF_IRQ_STATUS: begin
          status_clear = wbyte[sac_pkg::BIT_DONE];
        end
        sac_pkg::OFF_IRQ_MASK: begin
          s_next.irq_mask = wbyte[sac_pkg::BIT_DONE];
        end
        default: begin
          status_clear = 1'b0;
        end
      endcase
    end

    // read channel, answered the cycle after the address is taken
    if (axi_req.arvalid && !s_reg.rvalid) begin
      rd = read_word(s_reg, axi_req.araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[32] ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end else if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end

    // converter clock: one tick every prescale plus one machine cycles
    tick = (s_reg.pre_cnt == s_reg.prescale);

    // conversion sequencer
    case (s_reg.fsm)
      sac_pkg::SAC_IDLE: begin
        s_next.pre_cnt = 4'h0;
        s_next.period = 4'h0;
        // power as just written counts, so one write may power up and start
        if (s_next.power_on && (sw_start || ext_start)) begin
          s_next.fsm = sac_pkg::SAC_CONVERT;
          s_next.start_flag = 1'b1;
          s_next.sar = 10'h000;
        end
      end
      sac_pkg::SAC_CONVERT: begin
        s_next.pre_cnt = tick ? 4'h0 : s_reg.pre_cnt + 4'h1;
        if (tick) begin
          s_next.period = s_reg.period + 4'h1;
          if (s_reg.period == sac_pkg::SAMPLE_PERIODS - 4'h1) begin
            s_next.sar = 10'h200;
          end else if (s_reg.period >= sac_pkg::SAMPLE_PERIODS &&
                       s_reg.period <= sac_pkg::LAST_BIT_PERIOD) begin
            // keep the trial bit if the input is at or above it, then try the next
            s_next.sar[bit_idx] = comparator_high;
            if (bit_idx != 4'h0) begin
              s_next.sar[bit_idx - 4'h1] = 1'b1;
            end
          end else if (s_reg.period == sac_pkg::LAST_PERIOD) begin
            done = 1'b1;
          end
        end
        if (done) begin
          s_next.result = s_reg.sar;
          s_next.window_match_flag = wcm_new;
          done_irq = !s_reg.qualify || wcm_new;
          if (s_reg.cont && s_reg.power_on) begin
            s_next.sar = 10'h000;
          end else begin
            s_next.fsm = sac_pkg::SAC_IDLE;
            s_next.start_flag = 1'b0;
          end
        end
        // power dropped mid conversion: back to idle, result written only if this is the finishing cycle
        if (!s_reg.power_on) begin
          s_next.fsm = sac_pkg::SAC_IDLE;
          s_next.start_flag = 1'b0;
        end
      end
      default: begin
        s_next.fsm = sac_pkg::SAC_IDLE;
        s_next.start_flag = 1'b0;
      end
    endcase

    // sticky completion flag, a new event wins over a clear
    if (status_clear) begin
      s_next.irq_status = 1'b0;
    end
    if (done_irq) begin
      s_next.irq_status = 1'b1;
    end
  end

  // state register, every field resets to zero except the idle-high pin sync and pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.fsm <= sac_pkg::SAC_IDLE;
      s_reg.prescale <= sac_pkg::RST_PRESCALE;
      s_reg.channel <= sac_pkg::RST_CHANNEL;
      s_reg.win_hi <= sac_pkg::RST_WINDOW;
      s_reg.win_lo <= sac_pkg::RST_WINDOW;
      s_reg.power_on <= 1'b0;
      s_reg.ref_en <= 1'b0;
      s_reg.pin_sync <= 3'h7;
      s_reg.pin_level <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus handshakes
  assign axi_rsp.awready = !s_reg.aw_full && !s_reg.bvalid;
  assign axi_rsp.wready = !s_reg.w_full && !s_reg.bvalid;
  assign axi_rsp.bvalid = s_reg.bvalid;
  assign axi_rsp.bresp = s_reg.bresp;
  assign axi_rsp.arready = !s_reg.rvalid;
  assign axi_rsp.rvalid = s_reg.rvalid;
  assign axi_rsp.rdata = s_reg.rdata;
  assign axi_rsp.rresp = s_reg.rresp;

  // analog side controls
  assign analog.converter_enable = s_reg.power_on;
  assign analog.reference_enable = s_reg.ref_en;
  assign analog.channel_select = s_reg.channel;
  assign analog.sample_hold = (s_reg.fsm == sac_pkg::SAC_CONVERT) &&
                              (s_reg.period < sac_pkg::SAMPLE_PERIODS);
  assign analog.dac_code = s_reg.sar;

  // level interrupt while the unmasked flag stands
  assign irq = s_reg.irq_status && s_reg.irq_mask;

endmodule

// ==== bench/sac_conv_ctrl_properties.sv ====
// port checks for the converter control block
`timescale 1ns/1ns
module sac_conv_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sac_pkg::sac_axi_req_t axi_req,
  input wire sac_pkg::sac_axi_rsp_t axi_rsp,
  input wire logic comparator_high,
  input wire logic external_start_pin_n,
  input wire sac_pkg::sac_analog_t analog,
  input wire logic irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // converter side
  power_gate_a: assert property (analog.sample_hold |-> analog.converter_enable)
    else $error("sampling while off");
  reset_off_a: assert property (
    $rose(aresetn) |-> !analog.converter_enable && !analog.reference_enable)
    else $error("enables set after reset");
  sample_len_a: assert property ($rose(analog.sample_hold) |-> analog.sample_hold[*2])
    else $error("sampling too short");
  first_trial_a: assert property (
    $fell(analog.sample_hold) && analog.converter_enable |-> ##[0:1] analog.dac_code == 10'h200)
    else $error("first trial not midscale");
  irq_hold_a: assert property ($fell(irq) |-> $rose(axi_rsp.bvalid))
    else $error("irq dropped without write");
  // register bus side
  write_answer_a: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
    else $error("write not answered");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  write_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken during response");
  read_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken during response");
endmodule

bind sac_conv_ctrl sac_conv_ctrl_properties i_props (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .comparator_high(comparator_high), .external_start_pin_n(external_start_pin_n),
  .analog(analog), .irq(irq));

// ==== bench/sac_analog_model.sv ====
// behavioural analog inputs and comparator facing the converter
`timescale 1ns/1ns
module sac_analog_model (
  input wire sac_pkg::sac_analog_t analog,
  output logic comparator_high
);
  logic [9:0] level;
  // fixed level per channel; without power or reference the output wanders
  always_comb begin
    level = {analog.channel_select, 7'h00} + {7'h00, analog.channel_select} + 10'h05B;
    if (analog.converter_enable && analog.reference_enable) begin
      comparator_high = level >= analog.dac_code;
    end else begin
      comparator_high = ~analog.dac_code[0];
    end
  end
endmodule

// ==== bench/tb_sac_conv_ctrl.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_sac_conv_ctrl;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] rst;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rexp;
  } sac_row_t;
  logic aclk;
  logic aresetn;
  logic external_start_pin_n;
  logic comparator_high;
  logic irq;
  sac_pkg::sac_axi_req_t req;
  sac_pkg::sac_axi_rsp_t rsp;
  sac_pkg::sac_analog_t analog;
  int errors;
  int check_count;
  int n;
  logic [31:0] rd;
  logic [9:0] lv [8] = '{10'h05B, 10'h0DC, 10'h15D, 10'h1DE, 10'h25F, 10'h2E0, 10'h361, 10'h3E2};
  // address, reset value, write, response, readback
  sac_row_t rows [9] = '{
    '{8'h00, 32'h0, 32'h30, 2'h0, 32'h30}, '{8'h04, 32'h0, 32'hFF, 2'h0, 32'hFF},
    '{8'h08, 32'h0, 32'h80, 2'h0, 32'h80}, '{8'h14, 32'h0, 32'hFF, 2'h0, 32'hFF},
    '{8'h18, 32'h0, 32'h100, 2'h0, 32'h0}, '{8'h1C, 32'h0, 32'h0, 2'h0, 32'h0},
    '{8'h24, 32'h0, 32'h1, 2'h0, 32'h1}, '{8'h0C, 32'h0, 32'h55, 2'h0, 32'h0},
    '{8'h28, 32'h0, 32'h5A, 2'h2, 32'h0}};

  sac_conv_ctrl i_sac_conv_ctrl (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .comparator_high(comparator_high), .external_start_pin_n(external_start_pin_n),
    .analog(analog), .irq(irq));
  sac_analog_model i_sac_analog_model (.analog(analog), .comparator_high(comparator_high));

  // clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdr(a, 2'h0, rd);
    chk(nm, e, rd);
  endtask

  task automatic wait_for(input logic want_irq, input int lim);
    n = 0;
    while ((want_irq ? irq : analog.sample_hold) !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if ((want_irq ? irq : analog.sample_hold) !== 1'b1) begin
      errors++;
      $display("[FAIL] wait expected event seen timeout");
    end
  endtask

  // one software-started conversion with full readback
  task automatic conv(input logic [2:0] ch, input logic [3:0] p, input logic al);
    wr(8'h04, {24'h0, al, ch, p}, 2'h0);
    wr(8'h00, 32'h82, 2'h0);
    wait_for(1'b0, 20);
    chk("channel", {29'h0, ch}, {29'h0, analog.channel_select});
    wait_for(1'b1, 1200);
    chk("span", 16 * (p + 1), n);
    rchk("ctrl one", 8'h00, 32'h06);
    rchk("high", 8'h0C, al ? {30'h0, lv[ch][9:8]} : {24'h0, lv[ch][9:2]});
    rchk("low", 8'h10, {24'h0, lv[ch][7:0]});
    rchk("status", 8'h20, 32'h1);
    chk("one shot", 32'h0, {31'h0, analog.sample_hold});
    wr(8'h20, 32'h1, 2'h0);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end

  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    aresetn = 1'b0;
    external_start_pin_n = 1'b1;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rdr(rows[i].addr, rows[i].resp, rd);
      chk("reset value", rows[i].rst, rd);
      wr(rows[i].addr, rows[i].wdata, rows[i].resp);
      rdr(rows[i].addr, rows[i].resp, rd);
      chk("readback", rows[i].rexp, rd);
    end
    chk("ref pins", 32'h1, {31'h0, analog.reference_enable});
    chk("conv off", 32'h0, {31'h0, analog.converter_enable});
    $display("registers done");
    for (int c = 0; c < 8; c++) conv(c[2:0], 4'h9 + {2'h0, c[1:0]}, c[0]);
    $display("conversions done");
    // start without power is ignored
    wr(8'h00, 32'h80, 2'h0);
    repeat (5) @(posedge aclk);
    chk("unpowered", 32'h0, {31'h0, analog.sample_hold});
    // external trigger
    wr(8'h04, 32'h09, 2'h0);
    wr(8'h00, 32'h12, 2'h0);
    repeat (4) @(posedge aclk);
    chk("no ext start", 32'h0, {31'h0, analog.sample_hold});
    external_start_pin_n <= 1'b0;
    wait_for(1'b0, 10);
    chk("ext start", 32'h1, {31'h0, analog.sample_hold});
    repeat (200) @(posedge aclk);
    external_start_pin_n <= 1'b1;
    rchk("ext status", 8'h20, 32'h1);
    chk("ext one shot", 32'h0, {31'h0, analog.sample_hold});
    wr(8'h20, 32'h1, 2'h0);
    $display("external done");
    // window miss with qualify set
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h1C, 32'h2, 2'h0);
    wr(8'h00, 32'h82, 2'h0);
    repeat (200) @(posedge aclk);
    rchk("no match", 8'h00, 32'h02);
    rchk("qualified", 8'h20, 32'h0);
    // outside sense with qualify: the same miss now matches
    wr(8'h1C, 32'h3, 2'h0);
    wr(8'h00, 32'h82, 2'h0);
    repeat (200) @(posedge aclk);
    rchk("outside match", 8'h00, 32'h06);
    rchk("qualified hit", 8'h20, 32'h1);
    wr(8'h20, 32'h1, 2'h0);
    // a write with the low lane off is ignored
    req.wstrb <= 4'hE;
    wr(8'h14, 32'h77, 2'h0);
    req.wstrb <= 4'hF;
    rchk("lane off", 8'h14, 32'h0);
    wr(8'h1C, 32'h0, 2'h0);
    $display("window done");
    // continuous mode and masking
    wr(8'h00, 32'hA2, 2'h0);
    wait_for(1'b1, 400);
    chk("restart", 32'h1, {31'h0, analog.sample_hold});
    rdr(8'h00, 2'h0, rd);
    chk("busy", 32'h1, {31'h0, rd[7]});
    wr(8'h24, 32'h0, 2'h0);
    chk("masked", 32'h0, {31'h0, irq});
    wr(8'h24, 32'h1, 2'h0);
    chk("unmasked", 32'h1, {31'h0, irq});
    $display("continuous done");
    // reset in mid conversion
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("power rst", 32'h0, {31'h0, analog.converter_enable});
    rchk("ctrl one rst", 8'h00, 32'h0);
    rchk("ctrl two rst", 8'h04, 32'h0);
    rchk("ref rst", 8'h08, 32'h0);
    $display("reset done");
    finish_test();
  end
endmodule
